//--- logic/mirt_regs.vh
// Purpose: constants for the manchester ir transmitter
// Assumes: 200 MHz core clock, 16 MHz carrier timebase
// Notes: timebase derived from core clock by a fractional accumulator
`ifndef MIRT_REGS_VH
`define MIRT_REGS_VH
`define MIRT_CLK_HZ 200000000
`define MIRT_TIMER_HZ 16000000
`define MIRT_PERIOD_RESET 16'h01bc
`define MIRT_PULSE_RESET 16'h00de
`define MIRT_SLOT_CYCLES 6'h20
`define MIRT_FRAME_BITS 5'h0e
`define MIRT_START_BITS 2'h3
`define MIRT_FIFO_WIDTH 12
`define MIRT_FIFO_DEPTH 16
`define MIRT_FIFO_AW 4
`define MIRT_TOGGLE_POS 11
`define MIRT_ADDR_MSB 10
`define MIRT_ADDR_LSB 6
`define MIRT_DATA_MSB 5
`define MIRT_DATA_LSB 0
`endif

//--- logic/mirt_fifo.v
// Purpose: frame word fifo with valid/ready on both sides
// Assumes: single clock, width and depth as parameters
// Notes: read data held in a register until popped
`timescale 1ns/1ps
module mirt_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire reset_n,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output reg [WIDTH-1:0] out_data,
	output reg out_valid,
	input wire out_ready
);
	localparam [AW:0] FULL_COUNT = DEPTH;
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop_mem;
	wire load;
	assign in_ready = (count_reg != FULL_COUNT);
	assign push = in_valid && in_ready;
	// output register refills whenever empty or being taken
	assign load = (count_reg != {(AW+1){1'b0}}) && (!out_valid || out_ready);
	assign pop_mem = load;
	always @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
			out_data <= {WIDTH{1'b0}};
			out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			if (pop_mem)
				rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			if (push && !pop_mem)
				count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
			else if (!push && pop_mem)
				count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
			if (load)
			begin
				out_data <= mem[rd_ptr_reg];
				out_valid <= 1'b1;
			end
			else if (out_ready)
				out_valid <= 1'b0;
		end
	end
endmodule

//--- logic/mirt_transmitter.v
// Purpose: manchester coded ir frame generator with pwm carrier
// Assumes: 200 MHz clk, frame words queued through a 16 word fifo
// Notes: carrier timer advances on a 16 MHz enable from an accumulator
`timescale 1ns/1ps
`include "mirt_regs.vh"
// Overview of operation
// - carrier timer steps once per 16 MHz timebase tick, divide by one
// - counter wraps to zero after reaching period limit
// - carrier high while counter below pulse width value
// - pulse width may be lowered to about quarter period
// - period wrap flag pulses on every counter rollover
// - pulse end flag pulses when counter equals pulse width
// - period limit is sixteen bits, timer on its own prescaled tick
// - each half bit slot lasts exactly 32 carrier cycles
// - zero is carrier then silence, one is silence then carrier
// - frame holds exactly fourteen bits sent back to back
// - frame begins with two start bits, both one
// - toggle bit sent as supplied on frame_toggle, no key state kept here
// - five bit address follows the toggle bit
// - six bit command data follows address, ending frame
// - counter runs through frame, output gated per slot
// - carrier within about one percent, period and width trimmable
// - enabled output high in carrier high time, low otherwise
// - output enable changes only on half bit boundaries
module mirt_transmitter (
	input wire clk,
	input wire reset_n,
	input wire [15:0] period_limit_value,
	input wire [15:0] pulse_width_value,
	input wire frame_toggle,
	input wire [4:0] frame_address,
	input wire [5:0] frame_command,
	input wire frame_valid,
	output reg frame_ready,
	output reg ir_drive_output,
	output reg period_wrap_flag,
	output reg pulse_end_flag,
	output reg busy
);
	localparam ST_IDLE = 2'd0;
	localparam ST_SYNC = 2'd1;
	localparam ST_SEND = 2'd2;
	localparam [31:0] ACC_STEP = `MIRT_TIMER_HZ;
	localparam [31:0] ACC_MOD = `MIRT_CLK_HZ;

	reg [31:0] acc_reg;
	reg tick_reg;
	reg [15:0] count_reg;
	reg [1:0] state_reg;
	reg [13:0] shift_reg;
	reg [4:0] bits_left_reg;
	reg half_reg;
	reg [5:0] slot_cnt_reg;
	reg gate_reg;
	wire fifo_in_ready;
	wire [11:0] fifo_data;
	wire fifo_valid;
	wire fifo_take;
	wire wrap;
	wire slot_end;
	wire carrier;

	// manchester symbol level for one half of a bit
	function manch_level;
		input bit_value;
		input second_half;
		begin
			manch_level = bit_value ^ ~second_half;
		end
	endfunction

	mirt_fifo #(
		.WIDTH(`MIRT_FIFO_WIDTH),
		.DEPTH(`MIRT_FIFO_DEPTH),
		.AW(`MIRT_FIFO_AW)
	) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_data({frame_toggle, frame_address, frame_command}),
		.in_valid(frame_valid),
		.in_ready(fifo_in_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_take)
	);

	assign wrap = tick_reg && (count_reg >= period_limit_value);
	// slot closes on the 32nd rollover
	assign slot_end = wrap && (slot_cnt_reg == `MIRT_SLOT_CYCLES - 6'h01);
	// high time equals the compare value
	// lower width shortens duty, no floor enforced
	// limit and width are live trim inputs
	assign carrier = (count_reg < pulse_width_value);
	assign fifo_take = (state_reg == ST_IDLE) && fifo_valid;

	// fractional divider: 200 MHz to 16 MHz averages exactly, jitter one clk
	// timebase enable, divide by one
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			acc_reg <= 32'h00000000;
			tick_reg <= 1'b0;
		end
		else if (acc_reg + ACC_STEP >= ACC_MOD)
		begin
			acc_reg <= acc_reg + ACC_STEP - ACC_MOD;
			tick_reg <= 1'b1;
		end
		else
		begin
			acc_reg <= acc_reg + ACC_STEP;
			tick_reg <= 1'b0;
		end
	end

	// sixteen bit free running carrier timer
	// timer never stops during a frame
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			count_reg <= 16'h0000;
		else if (wrap)
			count_reg <= 16'h0000;
		else if (tick_reg)
			count_reg <= count_reg + 16'h0001;
	end

	// wrap flag, one pulse per carrier cycle
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			period_wrap_flag <= 1'b0;
			pulse_end_flag <= 1'b0;
		end
		else
		begin
			period_wrap_flag <= wrap;
			// flag on the tick that reaches the compare value, same edge the high time ends
			pulse_end_flag <= tick_reg && !wrap && (count_reg + 16'h0001 == pulse_width_value);
		end
	end

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg <= ST_IDLE;
			shift_reg <= 14'h0000;
			bits_left_reg <= 5'h00;
			half_reg <= 1'b0;
			slot_cnt_reg <= 6'h00;
			gate_reg <= 1'b0;
			busy <= 1'b0;
			frame_ready <= 1'b0;
		end
		else
		begin
			frame_ready <= fifo_in_ready;
			case (state_reg)
			ST_IDLE:
			begin
				gate_reg <= 1'b0;
				if (fifo_take)
				begin
					// two start ones ahead of the toggle bit
					// toggle taken as supplied by the key logic
					shift_reg <= {`MIRT_START_BITS, fifo_data};
					bits_left_reg <= `MIRT_FRAME_BITS;
					busy <= 1'b1;
					state_reg <= ST_SYNC;
				end
			end
			ST_SYNC:
			begin
				// align first slot to a carrier rollover
				if (wrap)
				begin
					half_reg <= 1'b0;
					slot_cnt_reg <= 6'h00;
					gate_reg <= manch_level(shift_reg[13], 1'b0);
					state_reg <= ST_SEND;
				end
			end
			ST_SEND:
			begin
				if (wrap)
					slot_cnt_reg <= slot_cnt_reg + 6'h01;
				// gate moves only at slot ends
				if (slot_end)
				begin
					slot_cnt_reg <= 6'h00;
					if (!half_reg)
					begin
						half_reg <= 1'b1;
						gate_reg <= manch_level(shift_reg[13], 1'b1);
					end
					else if (bits_left_reg == 5'h01)
					begin
						gate_reg <= 1'b0;
						busy <= 1'b0;
						state_reg <= ST_IDLE;
					end
					else
					begin
						half_reg <= 1'b0;
						shift_reg <= {shift_reg[12:0], 1'b0};
						bits_left_reg <= bits_left_reg - 5'h01;
						gate_reg <= manch_level(shift_reg[12], 1'b0);
					end
				end
			end
			default:
				state_reg <= ST_IDLE;
			endcase
		end
	end

	// carrier shape on the drive pin when gated on
	// pin low whenever gate is off
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ir_drive_output <= 1'b0;
		else
			ir_drive_output <= gate_reg && carrier;
	end
endmodule

//--- test/mirt_checker_assertions.sv
// Purpose: port checker for mirt_transmitter
// Assumes: timebase ticks more than 8 clocks apart, met by any period limit
// Notes: frame length judged by wraps seen while busy
`timescale 1ns/1ps
module mirt_checker (
	input wire clk,
	input wire reset_n,
	input wire [15:0] pulse_width_value,
	input wire frame_valid,
	input wire frame_ready,
	input wire ir_drive_output,
	input wire period_wrap_flag,
	input wire pulse_end_flag,
	input wire busy
);
	reg [10:0] wraps_reg;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n || !busy)
			wraps_reg <= 11'h000;
		else if (period_wrap_flag)
			wraps_reg <= wraps_reg + 11'h001;
	end
	property p_idle_quiet;
		!busy && !$past(busy) |-> !ir_drive_output;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle");
	property p_busy_start;
		frame_valid && frame_ready && !busy |-> ##[1:6] busy;
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("frame not started");
	property p_wrap_space;
		period_wrap_flag |=> !period_wrap_flag [*8];
	endproperty
	a_wrap_space: assert property (p_wrap_space) else $error("wrap too soon");
	property p_pulse_single;
		pulse_end_flag |=> !pulse_end_flag;
	endproperty
	a_pulse_single: assert property (p_pulse_single) else $error("pulse end long");
	property p_flags_apart;
		period_wrap_flag && pulse_width_value != 16'h0000 |-> !pulse_end_flag;
	endproperty
	a_flags_apart: assert property (p_flags_apart) else $error("flags together");
	property p_fall_by_end;
		pulse_end_flag |-> ##[0:1] !ir_drive_output;
	endproperty
	a_fall_by_end: assert property (p_fall_by_end) else $error("high past width");
	property p_rise_at_wrap;
		$rose(ir_drive_output) |-> period_wrap_flag || $past(period_wrap_flag);
	endproperty
	a_rise_at_wrap: assert property (p_rise_at_wrap) else $error("rise off wrap");
	property p_frame_wraps;
		$fell(busy) |-> wraps_reg >= 11'h37e && wraps_reg <= 11'h383;
	endproperty
	a_frame_wraps: assert property (p_frame_wraps) else $error("frame length");
endmodule
bind mirt_transmitter mirt_checker u_chk (.clk, .reset_n, .pulse_width_value, .frame_valid,
	.frame_ready, .ir_drive_output, .period_wrap_flag, .pulse_end_flag, .busy);

//--- test/mirt_led_stage.sv
// Purpose: transistor and led stage model
// Assumes: drive sampled on clk
// Notes: reports clocks of the last lit pulse
`timescale 1ns/1ps
module mirt_led_stage (
	input wire clk,
	input wire drive,
	output reg [15:0] last_width
);
	reg [15:0] run_reg = 16'h0000;
	initial last_width = 16'h0000;
	always @(posedge clk)
	begin
		if (drive === 1'b1)
			run_reg <= run_reg + 16'h0001;
		else if (run_reg != 16'h0000)
		begin
			last_width <= run_reg;
			run_reg <= 16'h0000;
		end
	end
endmodule

//--- test/mirt_transmitter_tb.sv
// Purpose: self-checking bench for mirt_transmitter
// Assumes: 200 MHz clk, short carrier period for frames
// Notes: fifo filled, not drained, to keep the run short
`timescale 1ns/1ps
module mirt_transmitter_tb;
	reg clk = 1'b0;
	reg reset_n = 1'b0;
	reg [15:0] period_limit_value = 16'h01bc;
	reg [15:0] pulse_width_value = 16'h00de;
	reg frame_toggle = 1'b0;
	reg [4:0] frame_address = 5'h00;
	reg [5:0] frame_command = 6'h00;
	reg frame_valid = 1'b0;
	wire frame_ready, ir_drive_output, period_wrap_flag, pulse_end_flag, busy;
	wire [15:0] width;
	integer err_count = 0;
	integer compares = 0;
	integer i, n, t1;
	bit rec = 0;
	bit seen = 0;
	bit got[$];
	bit exp[$];
	always #2.5 clk = ~clk;
	mirt_transmitter uut (.clk, .reset_n, .period_limit_value, .pulse_width_value,
		.frame_toggle, .frame_address, .frame_command, .frame_valid, .frame_ready,
		.ir_drive_output, .period_wrap_flag, .pulse_end_flag, .busy);
	mirt_led_stage led (.clk(clk), .drive(ir_drive_output), .last_width(width));
	always @(posedge clk)
	begin
		if (period_wrap_flag === 1'b1)
		begin
			if (rec)
				got.push_back(seen);
			seen <= (ir_drive_output === 1'b1);
		end
		else if (ir_drive_output === 1'b1)
			seen <= 1'b1;
	end
	task chk(input [31:0] s, input [31:0] e);
	begin
		compares++;
		if (s !== e)
		begin
			err_count++;
			$display("BAD %0t seen %0h want %0h", $time, s, e);
		end
	end
	endtask
	task wrap_up;
	begin
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task wt(input integer w, input integer m);
	begin
		n = 0;
		@(negedge clk);
		while ((w == 0 ? period_wrap_flag : w == 1 ? busy : !busy) !== 1'b1 && n < m)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= m)
		begin
			chk(0, 1);
			wrap_up;
		end
	end
	endtask
	task automatic trim(ref bit q[$]);
	begin
		while (q.size() > 0 && q[0] == 0)
			void'(q.pop_front());
		while (q.size() > 0 && q[$] == 0)
			void'(q.pop_back());
	end
	endtask
	task frame(input t, input [15:0] p);
		reg [13:0] b;
	begin
		pulse_width_value = p;
		frame_toggle = t;
		{frame_command, frame_address} = 11'($urandom);
		b = {2'h3, t, frame_address, frame_command};
		got.delete();
		exp.delete();
		frame_valid = 1'b1;
		@(negedge clk);
		frame_valid = 1'b0;
		wt(1, 20);
		rec = 1;
		wt(2, 60000);
		repeat (80) @(negedge clk);
		rec = 0;
		for (i = 13; i >= 0; i--)
		begin
			repeat (32) exp.push_back(!b[i]);
			repeat (32) exp.push_back(b[i]);
		end
		trim(got);
		trim(exp);
		chk(got.size(), exp.size());
		for (i = 0; i < exp.size() && i < got.size(); i++)
			chk(got[i], exp[i]);
		chk(width * 2 + 13 >= p * 25 && width * 2 <= p * 25 + 13, 1);
		$display("frame done toggle %0d", t);
	end
	endtask
	initial
	begin
		void'($urandom(14710));
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		chk({ir_drive_output, busy, frame_ready}, 3'h1);
		wt(0, 6000);
		i = 0;
		t1 = 0;
		do
		begin
			@(negedge clk);
			i++;
			if (pulse_end_flag === 1'b1)
				t1 = i;
		end while (period_wrap_flag !== 1'b1 && i < 6000);
		period_limit_value = 16'h0003;
		chk(i >= 5562 && i <= 5563, 1);
		chk(t1 >= 2774 && t1 <= 2776, 1);
		$display("carrier timing done");
		frame(1'b0, 16'h0002);
		frame(1'b1, 16'h0001);
		i = 0;
		frame_valid = 1'b1;
		while (frame_ready === 1'b1 && i < 40)
		begin
			@(negedge clk);
			i++;
		end
		frame_valid = 1'b0;
		chk(i >= 16 && i <= 19, 1);
		$display("fifo fill done");
		reset_n = 1'b0;
		repeat (3) @(negedge clk);
		chk({ir_drive_output, busy, frame_ready}, 3'h0);
		reset_n = 1'b1;
		repeat (3) @(negedge clk);
		chk({ir_drive_output, busy, frame_ready}, 3'h1);
		$display("second reset done");
		wrap_up;
	end
endmodule
